// file: hdl/cdp_config_port.sv
// module: configuration clock and data pin controller for four loading schemes
//
// Operation
// - passive schemes take the shift clock as input, sampling data on rising edges
// - active schemes drive the shift clock, timing every interface transfer
// - active schemes may hand the shift clock pin to user logic in user mode
// - in passive schemes the shift clock pin stays high impedance, also after configuration
// - memory-loading schemes drive the shift clock low after configuration
// - shift clock toggles after configuration leave the configured state untouched
// - serial schemes move one bit per clock on data line zero
// - after active serial, data line zero stays a dedicated user-readable input
// - after passive schemes, data line zero is a user pin per dual-use setting
// - after active parallel, data line zero is open-drain with optional user control
// - passive parallel moves a byte per clock; active parallel a 16-bit word
// - active serial drives data line one as a read command toward flash
// - after active serial, data line one stays a dedicated user-drivable output
// - during passive serial loading, data line one stays high impedance
// - data line one: dual-use after passive parallel, open-drain after active parallel
// - serial schemes hold data lines seven to two in high impedance while loading
// - lines seven to two: dual-use after passive parallel, open-drain after active parallel
// - once load-complete status rises, the block initialises then enters user mode
`timescale 1ns/1ps

module cdp_config_port #(
    parameter logic [7:0] READ_CMD_CODE = 8'h0B
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // scheme strap and status
    input wire logic [1:0] scheme_sel_in,
    input wire logic load_complete_status_in,
    output logic user_mode_out,
    // shift clock pin
    input wire logic cfg_shift_clock_in,
    output logic cfg_shift_clock_out,
    output logic cfg_shift_clock_oe_out,
    // data pins
    input wire logic [15:0] cfg_data_in,
    output logic [15:0] cfg_data_out,
    output logic [15:0] cfg_data_oe_out,
    // configuration word stream
    output logic [15:0] word_data_out,
    output logic word_valid_out,
    input wire logic word_ready_in,
    output logic load_ready_out,
    // user control after configuration
    input wire logic user_ctrl_en_in,
    input wire logic dual_use_user_in,
    input wire logic user_clk_out_in,
    input wire logic [15:0] user_data_out_in,
    input wire logic [15:0] user_data_oe_in,
    output logic [15:0] user_data_in_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [15:0] dat_s1;
    logic [15:0] dat_s2;
    logic done_s1;
    logic done_s2;
    logic [1:0] sel_s1;
    logic [1:0] sel_s2;

    // two flops on every pin before use
    always_ff @(posedge sys_clk_in) begin
        clk_s1 <= cfg_shift_clock_in;
        clk_s2 <= clk_s1;
        clk_s3 <= clk_s2;
        dat_s1 <= cfg_data_in;
        dat_s2 <= dat_s1;
        done_s1 <= load_complete_status_in;
        done_s2 <= done_s1;
        sel_s1 <= scheme_sel_in;
        sel_s2 <= sel_s1;
    end

    // ------------------------------------------------------------
    // scheme and state
    // ------------------------------------------------------------
    cdp_pkg::cdp_scheme_e scheme;
    cdp_pkg::cdp_state_e state;
    cdp_pkg::cdp_state_e next_state;
    logic [3:0] init_cnt;

    // strap caught while reset is held
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            scheme <= cdp_pkg::cdp_scheme_e'(sel_s2);
        end
    end

    // scheme decode
    wire is_ps = (scheme == cdp_pkg::passive_serial_scheme);
    wire is_pp = (scheme == cdp_pkg::passive_parallel_scheme);
    wire is_as = (scheme == cdp_pkg::active_serial_scheme);
    wire is_ap = (scheme == cdp_pkg::active_parallel_scheme);
    wire is_active = is_as | is_ap;
    wire is_serial = is_as | is_ps;
    wire loading = (state == cdp_pkg::st_load);
    wire in_user = (state == cdp_pkg::st_user);
    wire init_end = (state == cdp_pkg::st_init) && (init_cnt == cdp_pkg::INIT_LAST);

    // load, then initialise, then user mode
    always_comb begin
        next_state = state;
        unique case (state)
            cdp_pkg::st_load: begin
                if (done_s2) begin
                    next_state = cdp_pkg::st_init;
                end
            end
            cdp_pkg::st_init: begin
                if (init_end) begin
                    next_state = cdp_pkg::st_user;
                end
            end
            cdp_pkg::st_user: begin
                next_state = cdp_pkg::st_user;
            end
            default: next_state = cdp_pkg::st_load;
        endcase
    end

    // state register and initialisation counter
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            state <= cdp_pkg::st_load;
            init_cnt <= 4'h0;
        end else begin
            state <= next_state;
            init_cnt <= (state == cdp_pkg::st_init) ? init_cnt + 4'h1 : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // generated shift clock for active schemes
    // ------------------------------------------------------------
    logic gen_clk;
    logic [2:0] div_cnt;
    logic in_ready;

    // a low clock only rises while the buffer has room
    wire gen_run = loading & is_active & (in_ready | gen_clk);
    wire half_end = gen_run && (div_cnt == cdp_pkg::HALF_LAST);
    wire gen_rise = half_end & ~gen_clk;
    wire gen_fall = half_end & gen_clk;

    // divider
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            gen_clk <= 1'b0;
            div_cnt <= 3'h0;
        end else begin
            div_cnt <= half_end ? 3'h0 : (gen_run ? div_cnt + 3'h1 : div_cnt);
            gen_clk <= loading & (gen_clk ^ half_end);
        end
    end

    // ------------------------------------------------------------
    // read command toward the serial flash
    // ------------------------------------------------------------
    logic [31:0] cmd_sr;
    logic [5:0] cmd_cnt;

    wire cmd_done = ~is_as | (cmd_cnt == cdp_pkg::CMD_BITS);
    wire serial_cmd_out_to_flash = cmd_sr[31];

    // command bits change on falling shift clock edges
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            cmd_sr <= {READ_CMD_CODE, cdp_pkg::CMD_ADDR};
            cmd_cnt <= 6'h00;
        end else if (gen_fall && !cmd_done) begin
            cmd_sr <= {cmd_sr[30:0], 1'b1};
            cmd_cnt <= cmd_cnt + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // data capture and word assembly
    // ------------------------------------------------------------
    logic [15:0] asm_word;
    logic [4:0] asm_cnt;

    // passive: synced rising edge; active: data held through high phase
    wire pas_rise = clk_s2 & ~clk_s3;
    wire unit_tick = loading & (is_active ? (gen_fall & cmd_done) : pas_rise);
    wire [4:0] unit_last = is_serial ? cdp_pkg::SER_LAST :
        (is_pp ? cdp_pkg::BYTE_LAST : cdp_pkg::WORD_LAST);
    wire [15:0] ser_word = {dat_s2[0], asm_word[15:1]};
    wire [15:0] byte_word = {dat_s2[7:0], asm_word[15:8]};
    wire [15:0] next_asm = is_serial ? ser_word : (is_pp ? byte_word : dat_s2);
    wire unit_end = (asm_cnt == unit_last);
    wire push = unit_tick & unit_end;

    // shift units in, first unit lands lowest
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            asm_word <= 16'h0000;
            asm_cnt <= 5'h00;
        end else if (unit_tick) begin
            asm_word <= next_asm;
            asm_cnt <= unit_end ? 5'h00 : asm_cnt + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // two-entry word buffer
    // ------------------------------------------------------------
    logic [15:0] buf_mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] buf_cnt;

    wire pop = word_valid_out & word_ready_in;
    wire wr_en = push & in_ready;
    assign in_ready = (buf_cnt != 2'h2);
    assign word_valid_out = (buf_cnt != 2'h0);
    assign word_data_out = buf_mem[rd_ptr];
    assign load_ready_out = in_ready;

    // pointers and fill count
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            buf_cnt <= 2'h0;
        end else begin
            wr_ptr <= wr_ptr ^ wr_en;
            rd_ptr <= rd_ptr ^ pop;
            buf_cnt <= buf_cnt + {1'b0, wr_en} - {1'b0, pop};
        end
    end

    // word write
    always_ff @(posedge sys_clk_in) begin
        if (wr_en) begin
            buf_mem[wr_ptr] <= next_asm;
        end
    end

    // ------------------------------------------------------------
    // pin direction and drive
    // ------------------------------------------------------------
    cdp_pkg::cdp_pins_s pins;
    cdp_pkg::cdp_pins_s next_pins;

    // shift clock: generated while loading, low or user-owned after
    wire act_user = in_user & is_active;
    wire act_clk = act_user ? (user_ctrl_en_in & user_clk_out_in) : gen_clk;
    wire clk_oe = is_active;

    // general user pins after passive or serial loading
    wire [15:0] gp_mask = is_as ? cdp_pkg::AS_USER_MASK : cdp_pkg::ALL_MASK;
    wire gp_on = in_user & ~is_ap & dual_use_user_in;
    wire [15:0] gp_oe = gp_on ? (user_data_oe_in & gp_mask) : 16'h0000;

    // open-drain user control after active parallel loading
    wire od_on = in_user & is_ap & user_ctrl_en_in;
    wire [15:0] od_oe = od_on ? (user_data_oe_in & ~user_data_out_in) : 16'h0000;

    // data line one: command while loading, user output after
    wire as_d1 = in_user ? (~user_ctrl_en_in | user_data_out_in[1]) :
        serial_cmd_out_to_flash;
    wire [15:0] as_oe = is_as ? 16'h0002 : 16'h0000;

    // merge drivers; open-drain pins only ever pull low
    always_comb begin
        next_pins.clk_out = act_clk;
        next_pins.clk_oe = clk_oe;
        next_pins.dat_oe = as_oe | gp_oe | od_oe;
        next_pins.dat_out = 16'h0000;
        if (gp_on) begin
            next_pins.dat_out = user_data_out_in & gp_mask;
        end
        if (is_as) begin
            next_pins.dat_out[1] = as_d1;
        end
    end

    // pin register
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            pins <= cdp_pkg::PINS_RESET;
        end else begin
            pins <= next_pins;
        end
    end

    // user view of the data pins
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            user_data_in_out <= 16'h0000;
            user_mode_out <= 1'b0;
        end else begin
            user_data_in_out <= in_user ? dat_s2 : 16'h0000;
            user_mode_out <= in_user;
        end
    end

    assign cfg_shift_clock_out = pins.clk_out;
    assign cfg_shift_clock_oe_out = pins.clk_oe;
    assign cfg_data_out = pins.dat_out;
    assign cfg_data_oe_out = pins.dat_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    pas_clk_in_a: assert property (
        !is_active |=> !cfg_shift_clock_oe_out)
        else $error("shift clock driven in a passive scheme");

    act_clk_out_a: assert property (
        is_active && loading |=> cfg_shift_clock_oe_out && cfg_shift_clock_out == $past(gen_clk))
        else $error("active shift clock not driven from divider");

    clk_hand_a: assert property (
        act_user && user_ctrl_en_in |=> cfg_shift_clock_out == $past(user_clk_out_in))
        else $error("user clock not passed to pin");

    clk_park_low_a: assert property (
        act_user && !user_ctrl_en_in |=> cfg_shift_clock_oe_out && !cfg_shift_clock_out)
        else $error("shift clock not parked low");

    user_no_load_a: assert property (
        in_user |-> !push ##1 (buf_cnt <= $past(buf_cnt)))
        else $error("word taken after configuration");

    serial_bits_a: assert property (
        unit_tick && is_serial |=> asm_word[15] == $past(dat_s2[0]))
        else $error("serial bit not taken from data line zero");

    cmd_out_a: assert property (
        is_as && loading |=> cfg_data_oe_out[1] && cfg_data_out[1] == $past(cmd_sr[31]))
        else $error("read command not on data line one");

    ps_hiz_a: assert property (
        is_ps && !in_user |=> cfg_data_oe_out == 16'h0000)
        else $error("data pin driven while loading serially");

    open_drain_a: assert property (
        is_ap |=> (cfg_data_oe_out & cfg_data_out) == 16'h0000)
        else $error("open-drain pin driven high");

    init_enter_a: assert property (
        loading && done_s2 |=> state == cdp_pkg::st_init ##9 user_mode_out)
        else $error("user mode not reached after initialisation");

    clk_stall_a: assert property (
        is_active && loading && !gen_clk && !in_ready |=> !gen_clk)
        else $error("shift clock rose with the buffer full");

endmodule : cdp_config_port

// file: hdl/cdp_pkg.sv
// package: constants and types of the configuration data port
package cdp_pkg;

    // ------------------------------------------------------------
    // loading schemes and controller states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        passive_serial_scheme,
        passive_parallel_scheme,
        active_serial_scheme,
        active_parallel_scheme
    } cdp_scheme_e;

    typedef enum logic [1:0] {
        st_load,
        st_init,
        st_user
    } cdp_state_e;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_PERIOD_NS = 40;
    localparam int SHIFT_HALF_NS = 160;
    localparam int HALF_CYCLES = (SHIFT_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [2:0] HALF_LAST = 3'(HALF_CYCLES - 1);
    localparam int INIT_NS = 320;
    localparam int INIT_CYCLES = (INIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam logic [3:0] INIT_LAST = 4'(INIT_CYCLES - 1);

    // ------------------------------------------------------------
    // framing and pin masks
    // ------------------------------------------------------------
    localparam logic [5:0] CMD_BITS = 6'h20;
    localparam logic [23:0] CMD_ADDR = 24'h000000;
    localparam logic [4:0] SER_LAST = 5'h0F;
    localparam logic [4:0] BYTE_LAST = 5'h01;
    localparam logic [4:0] WORD_LAST = 5'h00;
    localparam logic [15:0] AS_USER_MASK = 16'hFFFC;
    localparam logic [15:0] ALL_MASK = 16'hFFFF;

    // pin drive bundle for the shift clock and data pins
    typedef struct packed {
        logic clk_out;
        logic clk_oe;
        logic [15:0] dat_out;
        logic [15:0] dat_oe;
    } cdp_pins_s;

    localparam cdp_pins_s PINS_RESET = '{1'b0, 1'b0, 16'h0000, 16'h0000};

endpackage : cdp_pkg

// file: verif/cdp_far_model.sv
// far-side model: host for the passive schemes, flash for the active ones
`timescale 1ns/1ps

module cdp_far_model #(
    parameter int NW = 6,
    parameter logic [7:0] READ_CODE = 8'h0B
) (
    // bench control
    input wire logic [1:0] scheme_in,
    input wire logic run_in,
    input wire logic [15:0] base_in,
    input wire logic load_ready_in,
    // board levels
    input wire logic clk_pin_in,
    input wire logic [15:0] data_pin_in,
    // model drive
    output logic host_clk_out,
    output logic [15:0] dat_out,
    output logic [15:0] dat_oe_out,
    output int cmd_err_out
);
    logic [31:0] cmd;
    logic [15:0] w;

    // word k of the image
    function automatic logic [15:0] wd(input int k);
        return base_in + 16'(k) * 16'h1F3B;
    endfunction : wd

    // one load; the flash keeps streaming until run_in drops
    task automatic serve();
        int n;
        n = scheme_in[0] ? 2 : 16;
        if (!scheme_in[1]) begin
            dat_oe_out = scheme_in[0] ? 16'h00FF : 16'h0001;
            for (int k = 0; k < NW * n; k++) begin
                w = wd(k / n);
                if (k % n == n - 1) wait (load_ready_in); // host never overruns
                dat_out = scheme_in[0] ? {8'h00, w[8 * (k % n) +: 8]}
                    : {15'h0000, w[k % n]};
                #160 host_clk_out = 1'b1;
                #160 host_clk_out = 1'b0;
            end
            dat_oe_out = 16'h0000;
        end else if (scheme_in[0]) begin
            dat_oe_out = 16'hFFFF;
            for (int k = 0; k >= 0; k++) begin
                dat_out = wd(k);
                @(negedge clk_pin_in);
            end
        end else begin
            repeat (32) @(posedge clk_pin_in) cmd = {cmd[30:0], data_pin_in[1]};
            if (cmd !== {READ_CODE, 24'h000000}) cmd_err_out++;
            dat_oe_out = 16'h0001;
            for (int k = 0; k >= 0; k++) begin
                @(negedge clk_pin_in);
                w = wd(k / 16);
                dat_out = {15'h0000, w[k % 16]};
            end
        end
    endtask : serve

    // released lines are left to the board
    always begin
        host_clk_out = 1'b0;
        dat_oe_out = 16'h0000;
        dat_out = 16'h0000;
        wait (run_in);
        fork
            serve();
            wait (!run_in);
        join_any
        disable fork;
        wait (!run_in);
    end
endmodule : cdp_far_model

// file: verif/test_cdp_config_port.sv
// self-checking bench of the configuration data port in all four schemes
`timescale 1ns/1ps

`define CHK(what, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", what, e, g); end end

module test_cdp_config_port;
    // ----
    // pins and bench state
    // ----
    localparam int NW = 6;
    logic sys_clk_in, rstn_in, ldc, rdy, uctl, dual, uclk, run, tog, fl_q, stall;
    logic ck_out, ck_oe, host_clk, ck_pin, umode, valid, lrdy;
    logic [1:0] sch;
    logic [15:0] uout, uoe, base, dout, doe, m_out, m_oe, dpin, fl, wdat, udin;
    logic [15:0] got[$];
    int error_cnt, n_tests, cmd_err;

    // board level of the lines; in active serial lines one and zero have pull-ups, others wander
    assign ck_pin = ck_oe ? ck_out : (host_clk | sch[1]) ^ tog;
    assign fl = {16{fl_q}} | {14'h0000, {2{sch == 2'b10}}};
    assign dpin = (doe & dout) | (~doe & m_oe & m_out) | (~doe & ~m_oe & fl);

    cdp_config_port i_cdp_config_port (
        .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .scheme_sel_in(sch),
        .load_complete_status_in(ldc), .user_mode_out(umode),
        .cfg_shift_clock_in(ck_pin), .cfg_shift_clock_out(ck_out),
        .cfg_shift_clock_oe_out(ck_oe), .cfg_data_in(dpin), .cfg_data_out(dout),
        .cfg_data_oe_out(doe), .word_data_out(wdat), .word_valid_out(valid),
        .word_ready_in(rdy), .load_ready_out(lrdy), .user_ctrl_en_in(uctl),
        .dual_use_user_in(dual), .user_clk_out_in(uclk), .user_data_out_in(uout),
        .user_data_oe_in(uoe), .user_data_in_out(udin));

    cdp_far_model #(.NW(NW)) i_cdp_far_model (
        .scheme_in(sch), .run_in(run), .base_in(base), .load_ready_in(lrdy),
        .clk_pin_in(ck_pin), .data_pin_in(dpin), .host_clk_out(host_clk),
        .dat_out(m_out), .dat_oe_out(m_oe), .cmd_err_out(cmd_err));

    // clock
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    // wandering level, random consumer stalls, word capture
    always @(posedge sys_clk_in) begin
        fl_q <= #1 ~fl_q;
        rdy <= #1 !stall && ($urandom % 4 != 0);
        if (rstn_in && valid && rdy) got.push_back(wdat);
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick

    function automatic logic [15:0] exp_w(input int k);
        return base + 16'(k) * 16'h1F3B;
    endfunction : exp_w

    // data drive enables in user mode
    function automatic logic [15:0] exp_oe(input logic [1:0] s, input logic c);
        logic [15:0] du;
        du = dual ? uoe : 16'h0000;
        case (s)
            2'b10: return {du[15:2], 2'b10};
            2'b11: return c ? (uoe & ~uout) : 16'h0000;
            default: return du;
        endcase
    endfunction : exp_oe

    // one whole load and user-mode pass in scheme s
    task automatic run_scheme(input logic [1:0] s);
        int t;
        logic [15:0] eo, ex, pu;
        sch = s;
        rstn_in = 1'b0;
        run = 1'b0;
        ldc = 1'b0;
        uctl = 1'b0;
        stall = 1'b1;
        base = 16'($urandom);
        dual = 1'($urandom);
        got.delete();
        tick(3);
        `CHK("reset drive", 17'h00000, {ck_oe, doe})
        rstn_in = 1'b1;
        tick(4);
        `CHK("clock dir", s[1], ck_oe)
        `CHK("data dir", (s == 2'b10) ? 16'h0002 : 16'h0000, doe)
        run = 1'b1;
        for (t = 0; t < 5000 && lrdy; t++) tick(1);
        tick(20);
        `CHK("full buffer", 2'b10, {valid, lrdy})
        stall = 1'b0;
        for (t = 0; t < 9000 && got.size() < NW; t++) tick(1);
        for (int i = 0; i < NW; i++) `CHK("word", exp_w(i), got[i])
        `CHK("read command", 0, cmd_err)
        run = 1'b0;
        ldc = 1'b1;
        for (t = 0; t < 24 && umode !== 1'b1; t++) tick(1);
        `CHK("user mode", 1'b1, umode)
        for (int c = 0; c < 2; c++) begin
            uctl = 1'(c);
            uclk = 1'($urandom);
            uout = 16'($urandom);
            uoe = 16'($urandom);
            tick(5);
            eo = exp_oe(s, uctl);
            ex = !s[1] ? uout : s[0] ? 16'h0000 : {uout[15:2], ~uctl | uout[1], 1'b0};
            pu = {15'h0000, s == 2'b10};
            `CHK("clock oe", s[1], ck_oe)
            `CHK("clock out", s[1] & uctl & uclk, s[1] & ck_out)
            `CHK("data oe", eo, doe)
            `CHK("data out", ex & eo, dout & eo)
            `CHK("user input", (ex & eo) | pu, udin & (eo | pu))
        end
        repeat (8) begin
            tog = ~tog;
            uclk = ~uclk;
            #160;
        end
        tick(2);
        `CHK("after toggles", 2'b10, {umode, valid})
    endtask : run_scheme

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        {rstn_in, ldc, uctl, dual, uclk, run, tog, fl_q, rdy} = '0;
        {sch, uout, uoe, base} = '0;
        stall = 1'b1;
        void'($urandom(32'h7D64FB9E));
        for (int s = 0; s < 4; s++) run_scheme(2'(s));
        give_verdict();
    end

    // watchdog
    initial begin
        #3000000;
        error_cnt++;
        give_verdict();
    end
endmodule : test_cdp_config_port
